// ==== rtl/switch_check_limit_and_result.sv ====
// Switch test limits, self-test result register and their Avalon-MM register slave.
//
// Behaviour
// R1: The block holds a 14-bit upper limit for the switch conducting and sense-wire tests.
// R2: Each test result greater than the upper limit raises a balancing-switch alert.
// R3: A test result below the upper limit is normal and raises no upper-limit alert.
// R4: Software should write the limits before it starts a diagnostic measurement.
// R5: Bits 1 and 0 of the upper-limit register read as zero whatever was written.
// R6: The result register holds the 14-bit result of the picked self-test measurement in bits 15 to 2.
// R7: Bits 1 and 0 of the result register read as zero.
// R8: The result register is read-only, ignores writes and resets to zero.
// R9: Each test result below a separate 14-bit lower limit also raises a balancing-switch alert.
// R10: Comparison uses the left-aligned values and is made for every single result of the test.
`timescale 1ns/10ps
`include "switch_check_map.svh"
module switch_check_limit_and_result #(
    parameter int ADDR_W = 10,
    parameter int RES_W = 14
) (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // Avalon-MM slave, byte addressed
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // ADC result stream
    input wire switch_check_pkg::adc_word_s adc,
    // Setup towards the ADC sequencer
    output logic test_en,
    output logic [2:0] selftest_pick,
    // Alerts
    output logic switch_alert,
    output logic irq
);
    // Register state.
    logic [RES_W-1:0] upper_r;
    logic [RES_W-1:0] lower_r;
    logic [RES_W-1:0] result_r;
    logic [`STAT_W-1:0] mask_r;
    switch_check_pkg::setup_s setup_r;
    switch_check_pkg::bus_state_e state_r;
    logic [`STAT_W-1:0] status_r;
    logic [`STAT_W-1:0] reported_r;
    logic high_r;
    logic low_r;
    logic irq_r;
    logic alert_r;

    // Address decode.
    wire logic [7:0] idx = 8'(address[ADDR_W-1:2]);
    wire logic aligned = (address[1:0] == 2'h0);
    wire logic hit_upper = aligned && (idx == `IDX_UPPER_LIMIT);
    wire logic hit_lower = aligned && (idx == `IDX_LOWER_LIMIT);
    wire logic hit_result = aligned && (idx == `IDX_RESULT);
    wire logic hit_setup = aligned && (idx == `IDX_SETUP);
    wire logic hit_status = aligned && (idx == `IDX_STATUS);
    wire logic hit_mask = aligned && (idx == `IDX_MASK);

    // A request is taken in idle and completes at the edge where waitrequest is low.
    wire logic take = (state_r == switch_check_pkg::BUS_IDLE) && (read || write);
    wire logic done = (state_r == switch_check_pkg::BUS_DONE);
    wire logic wr_fire = done && write;
    wire logic rd_fire = done && read;

    // Read data mux; unmapped addresses read as zero.
    wire logic [15:0] rd_upper = {upper_r, 2'b00}; // R5
    wire logic [15:0] rd_lower = {lower_r, 2'b00};
    wire logic [15:0] rd_result = {result_r, 2'b00}; // R6 R7
    wire logic [15:0] rd_setup = {12'h000, setup_r};
    wire logic [15:0] rd_status = {13'h0, status_r};
    wire logic [15:0] rd_mask = {13'h0, mask_r};
    wire logic [15:0] rd_mux =
        hit_upper ? rd_upper :
        hit_lower ? rd_lower :
        hit_result ? rd_result :
        hit_setup ? rd_setup :
        hit_status ? rd_status :
        hit_mask ? rd_mask : 16'h0000;

    // Only the bits that the read actually returned are cleared, so an event that
    // lands between the data capture and the completing edge survives.
    wire logic [`STAT_W-1:0] stat_clear = (rd_fire && hit_status) ? reported_r : `RST_STATUS;

    // Self-test capture; pick zero means no measurement, so nothing is stored.
    wire logic capture = adc.valid && adc.is_selftest_measurement_result && (setup_r.pick != `PICK_NONE); // R6

    wire logic [`STAT_W-1:0] events = {capture, low_r, high_r};

    // Bus handshake.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= switch_check_pkg::BUS_IDLE;
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
            reported_r <= `RST_STATUS;
        end else if (ce) begin
            unique case (state_r)
                switch_check_pkg::BUS_IDLE: begin
                    if (take) begin
                        state_r <= switch_check_pkg::BUS_DONE;
                        waitrequest <= 1'b0;
                        readdata <= {16'h0000, rd_mux};
                        reported_r <= status_r;
                    end
                end
                switch_check_pkg::BUS_DONE: begin
                    state_r <= switch_check_pkg::BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Writable registers; the low two bits of a limit write are dropped.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            upper_r <= `RST_UPPER_LIMIT;
            lower_r <= `RST_LOWER_LIMIT;
            setup_r <= `RST_SETUP;
            mask_r <= `RST_MASK;
        end else if (ce && wr_fire) begin
            if (hit_upper) begin
                upper_r <= writedata[`VAL_MSB:`VAL_LSB]; // R1 R5
            end
            if (hit_lower) begin
                lower_r <= writedata[`VAL_MSB:`VAL_LSB]; // R9
            end
            if (hit_setup) begin
                setup_r <= writedata[`SETUP_PICK_MSB:`SETUP_TEST_EN_BIT];
            end
            if (hit_mask) begin
                mask_r <= writedata[`STAT_W-1:0];
            end
        end
    end

    // Result register: loaded only by the ADC, never by the bus.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            result_r <= `RST_RESULT; // R8
        end else if (ce && capture) begin
            result_r <= adc.data[`VAL_MSB:`VAL_LSB]; // R6
        end
    end

    // Setup outputs follow their register one cycle later.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            test_en <= 1'b0;
            selftest_pick <= `PICK_NONE;
        end else if (ce) begin
            test_en <= setup_r.test_en;
            selftest_pick <= setup_r.pick;
        end
    end

    // The limits are not latched per test; a limit changed mid-test applies to the next result.
    limit_check #(
        .RES_W(RES_W)
    ) u_limit (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .adc(adc),
        .enable(setup_r.test_en),
        .upper(upper_r),
        .lower(lower_r),
        .high_r(high_r),
        .low_r(low_r),
        .alert_r(alert_r)
    );

    sticky_status #(
        .W(`STAT_W)
    ) u_status (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .set(events),
        .clear(stat_clear),
        .mask(mask_r),
        .status_r(status_r),
        .irq_r(irq_r)
    );

    assign switch_alert = alert_r;
    assign irq = irq_r;

    // Checks.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    wire logic [RES_W-1:0] adc_res = adc.data[`VAL_MSB:`VAL_LSB];
    wire logic judged = ce && adc.valid && !adc.is_selftest_measurement_result && setup_r.test_en;

    sequence s_taken;
        ce && take;
    endsequence

    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence

    a_bus_answer: assert property (s_taken |=> s_answer)
        else $error("request not answered in the expected cycles");

    a_upper_read_low: assert property (rd_fire && hit_upper |-> readdata[1:0] == 2'h0 && readdata[15:2] == upper_r) // R5
        else $error("upper limit read back wrongly");

    a_result_read: assert property (rd_fire && hit_result |-> readdata == {16'h0000, $past(result_r), 2'b00}) // R7
        else $error("result register read back wrongly");

    a_result_readonly: assert property (ce && wr_fire && hit_result && !capture |=> $stable(result_r)) // R8
        else $error("write changed the result register");

    a_result_load: assert property (ce && capture |=> result_r == $past(adc_res)) // R6
        else $error("self-test result not captured");

    a_upper_write: assert property (ce && wr_fire && hit_upper |=> upper_r == $past(writedata[15:2])) // R1
        else $error("upper limit write lost");

    a_high_alert: assert property (judged && adc_res > upper_r |=> high_r && switch_alert) // R2
        else $error("result above upper limit gave no alert");

    a_high_quiet: assert property (judged && adc_res <= upper_r |=> !high_r) // R3
        else $error("alert raised for result not above upper limit");

    a_low_alert: assert property (judged && adc_res < lower_r |=> low_r && switch_alert) // R9
        else $error("result below lower limit gave no alert");

    a_alert_each: assert property (ce && !judged |=> !switch_alert) // R10
        else $error("alert without a judged result");

    a_status_sticky: assert property (ce && high_r |=> status_r[`STAT_HIGH_BIT]) // R2
        else $error("high alert not held in status");

    // Further checks on the bus, the limits, the sticky status and the clock enable.
    // Each one that looks across an edge, apart from the hold checks and a_freeze, is gated by ce, because a low ce freezes every flop.
    wire logic any_hit = hit_upper || hit_lower || hit_result || hit_setup || hit_status || hit_mask;
    wire logic any_event = ce && (capture || high_r || low_r);

    sequence s_lower_write;
        ce && wr_fire && hit_lower;
    endsequence

    sequence s_status_read;
        ce && rd_fire && hit_status && !any_event;
    endsequence

    sequence s_selftest_measurement_result_kept;
        ce && adc.valid && adc.is_selftest_measurement_result && (setup_r.pick != `PICK_NONE);
    endsequence

    sequence s_selftest_measurement_result_dropped;
        ce && adc.valid && adc.is_selftest_measurement_result && (setup_r.pick == `PICK_NONE);
    endsequence

    sequence s_done_step;
        ce && done;
    endsequence

    // Bus handshake and read data.
    a_idle_wait: assert property (state_r == switch_check_pkg::BUS_IDLE |-> waitrequest)
        else $error("waitrequest low with no request in hand");

    a_ready_once: assert property (ce && !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_take_state: assert property (s_taken |=> done)
        else $error("taken request did not reach the answer state");

    a_done_back: assert property (s_done_step |=> state_r == switch_check_pkg::BUS_IDLE)
        else $error("answer state not left after one cycle");

    a_read_top_zero: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");

    a_read_data_hold: assert property (ce && !take |=> $stable(readdata))
        else $error("read data changed without a request");

    a_unmapped_zero: assert property (rd_fire && !any_hit |-> readdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // Limit and result registers.
    a_lower_read: assert property (rd_fire && hit_lower |-> readdata == {16'h0000, lower_r, 2'b00}) // R9
        else $error("lower limit read back wrongly");

    a_lower_write: assert property (s_lower_write |=> lower_r == $past(writedata[15:2])) // R9
        else $error("lower limit write lost");

    a_upper_hold: assert property (!(ce && wr_fire && hit_upper) |=> $stable(upper_r)) // R1
        else $error("upper limit changed without a write");

    a_lower_hold: assert property (!(ce && wr_fire && hit_lower) |=> $stable(lower_r)) // R9
        else $error("lower limit changed without a write");

    a_result_hold: assert property (!(ce && capture) |=> $stable(result_r)) // R8
        else $error("result register changed without a capture");

    a_pick_none: assert property (s_selftest_measurement_result_dropped |=> $stable(result_r)) // R6
        else $error("measurement stored although none was picked");

    // Sticky status, mask and interrupt.
    a_selftest_measurement_result_sticky: assert property (s_selftest_measurement_result_kept |=> status_r[`STAT_RESULT_BIT]) // R6
        else $error("captured result not held in status");

    a_low_sticky: assert property (ce && low_r |=> status_r[`STAT_LOW_BIT]) // R9
        else $error("low alert not held in status");

    a_low_quiet: assert property (judged && adc_res >= lower_r |=> !low_r) // R9
        else $error("alert raised for result not below lower limit");

    a_status_clear: assert property (s_status_read |=> (status_r & $past(reported_r)) == 3'h0)
        else $error("status read did not clear the returned bits");

    a_status_keep: assert property (ce && !(rd_fire && hit_status) |=> ($past(status_r) & ~status_r) == 3'h0)
        else $error("status bit lost without a read");

    a_status_event: assert property (ce && events == 3'h0 |=> (status_r & ~$past(status_r)) == 3'h0)
        else $error("status bit set without an event");

    a_irq_level: assert property (ce |=> irq == (|(status_r & $past(mask_r))))
        else $error("interrupt level disagrees with status and mask");

    // Setup register, its outputs and the clock enable.
    a_setup_write: assert property (ce && wr_fire && hit_setup |=> setup_r == $past(writedata[3:0]))
        else $error("setup write lost");

    a_test_en_follow: assert property (ce |=> test_en == $past(setup_r.test_en))
        else $error("test enable output does not follow setup");

    a_pick_follow: assert property (ce |=> selftest_pick == $past(setup_r.pick))
        else $error("pick output does not follow setup");

    a_mask_write: assert property (ce && wr_fire && hit_mask |=> mask_r == $past(writedata[`STAT_W-1:0]))
        else $error("mask write lost");

    a_freeze: assert property (!ce |=> $stable(status_r) && $stable(state_r) && $stable(switch_alert) && $stable(irq))
        else $error("state moved while clock enable was low");
endmodule

// ==== rtl/switch_check_map.svh ====
// Register indices, field positions and reset values of the switch check block.
`ifndef SWITCH_CHECK_MAP_SVH
`define SWITCH_CHECK_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_LOWER_LIMIT 8'h4C
`define IDX_UPPER_LIMIT 8'h4D
`define IDX_RESULT 8'h50
`define IDX_SETUP 8'h60
`define IDX_STATUS 8'h61
`define IDX_MASK 8'h62

// Reset values.
`define RST_UPPER_LIMIT 14'h0000
`define RST_LOWER_LIMIT 14'h0000
`define RST_RESULT 14'h0000
`define RST_SETUP 4'h0
`define RST_MASK 3'h0
`define RST_STATUS 3'h0

// Left-aligned 14-bit values sit in bits 15 down to 2 of a 16-bit word.
`define VAL_MSB 15
`define VAL_LSB 2

// Setup register fields.
`define SETUP_TEST_EN_BIT 0
`define SETUP_PICK_LSB 1
`define SETUP_PICK_MSB 3
`define PICK_NONE 3'h0

// Status and mask register fields.
`define STAT_HIGH_BIT 0
`define STAT_LOW_BIT 1
`define STAT_RESULT_BIT 2
`define STAT_W 3

`endif

// ==== rtl/switch_check_pkg.sv ====
// Types shared by the switch check block and its bench.
package switch_check_pkg;

    // One ADC word; is_selftest_measurement_result marks a self-test measurement rather than a switch test result.
    typedef struct packed {
        logic valid;
        logic is_selftest_measurement_result;
        logic [15:0] data;
    } adc_word_s;

    // Software-written setup of the test logic.
    typedef struct packed {
        logic [2:0] pick;
        logic test_en;
    } setup_s;

    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_DONE
    } bus_state_e;

endpackage

// ==== rtl/limit_check.sv ====
// Window comparison of switch test results against the upper and lower limits.
`timescale 1ns/10ps
`include "switch_check_map.svh"
module limit_check #(
    parameter int RES_W = 14
) (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // Result stream and limits
    input wire switch_check_pkg::adc_word_s adc,
    input wire logic enable,
    input wire logic [RES_W-1:0] upper,
    input wire logic [RES_W-1:0] lower,
    // One-cycle alert pulses
    output logic high_r,
    output logic low_r,
    output logic alert_r
);
    // Both sides are left-aligned words, so the raw 14-bit fields compare directly.
    wire logic [RES_W-1:0] res = adc.data[`VAL_MSB:`VAL_LSB]; // R10
    wire logic judge = adc.valid && !adc.is_selftest_measurement_result && enable; // R10
    wire logic above = judge && (res > upper); // R2 R3
    wire logic below = judge && (res < lower); // R9

    always_ff @(posedge core_clk) begin
        if (reset) begin
            high_r <= 1'b0;
            low_r <= 1'b0;
            alert_r <= 1'b0;
        end else if (ce) begin
            high_r <= above;
            low_r <= below;
            alert_r <= above || below;
        end
    end
endmodule

// ==== rtl/sticky_status.sv ====
// Sticky event bits with read-clear, mask and one level interrupt.
`timescale 1ns/10ps
module sticky_status #(
    parameter int W = 3
) (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // Events and software side
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clear,
    input wire logic [W-1:0] mask,
    // State
    output logic [W-1:0] status_r,
    output logic irq_r
);
    wire logic [W-1:0] status_nxt;

    // A set in the same cycle as the clear wins, so no event is lost.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign status_nxt[i] = set[i] || (status_r[i] && !clear[i]);
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_r <= '0;
            irq_r <= 1'b0;
        end else if (ce) begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask);
        end
    end
endmodule

// ==== tb/ctrl_model.sv ====
// Register-bus master standing in for the system controller.
`timescale 1ns/10ps
module ctrl_model (
    // Clock
    input wire logic core_clk,
    // Avalon-MM master side
    output logic [9:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    logic [31:0] dummy;

    initial begin
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
    end

    // Released lines show the inverse, so a slave that keeps using stale values is caught.
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge core_clk);
        address <= a;
        writedata <= {16'h0000, d};
        read <= !wr;
        write <= wr;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        address <= ~a;
        writedata <= {16'hFFFF, ~d};
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] q);
        xfer(1'b0, a, 16'h0000, q);
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        xfer(1'b1, a, d, dummy);
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the switch check block.
`timescale 1ns/10ps
module tb;
    logic core_clk;
    logic reset;
    logic ce;
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    switch_check_pkg::adc_word_s adc;
    logic test_en;
    logic [2:0] selftest_pick;
    logic switch_alert;
    logic irq;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h1738;
    logic [31:0] q;
    logic [15:0] up;
    logic [15:0] lo;
    logic [15:0] d;
    logic [2:0] acc;

    switch_check_limit_and_result uut (.core_clk(core_clk), .reset(reset), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .adc(adc), .test_en(test_en), .selftest_pick(selftest_pick), .switch_alert(switch_alert), .irq(irq));
    ctrl_model host (.core_clk(core_clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic exp_alert(input logic [15:0] v, input logic [15:0] hi, input logic [15:0] lw);
        return (v[15:2] > hi[15:2]) || (v[15:2] < lw[15:2]);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic end_sim;
        $display("Counts: %0d compared, %0d mismatched", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Present one ADC word for exactly one cycle, then let the registered answer land.
    task automatic send(input logic selftest_measurement_result, input logic [15:0] v);
        @(posedge core_clk);
        adc <= {1'b1, selftest_measurement_result, v};
        @(posedge core_clk);
        adc <= {1'b0, 1'b0, ~v};
        #1;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        adc = '0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        host.rd(10'h134, q);
        chk(q, 32'h00000000);
        host.rd(10'h140, q);
        chk(q, 32'h00000000);
        host.rd(10'h130, q);
        chk(q, 32'h00000000);
        host.rd(10'h3FC, q);
        chk(q, 32'h00000000);
        $display("test reset done");
        seed = xs(seed);
        up = {2'b10, seed[13:0]};
        lo = {2'b01, seed[29:16]};
        // Limits go in before any measurement; low bits are set to show they read back as zero.
        host.wr(10'h134, up | 16'h0003);
        host.wr(10'h130, lo | 16'h0003);
        host.rd(10'h134, q);
        chk(q, {16'h0000, up & 16'hFFFC});
        host.rd(10'h130, q);
        chk(q, {16'h0000, lo & 16'hFFFC});
        host.wr(10'h188, 16'h0007);
        host.wr(10'h180, 16'h0001);
        acc = 3'h0;
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            d = seed[15:0] & 16'hFFFC;
            if (i == 0) d = up & 16'hFFFC;
            if (i == 1) d = (up & 16'hFFFC) + 16'h0004;
            if (i == 2) d = lo & 16'hFFFC;
            if (i == 3) d = (lo & 16'hFFFC) - 16'h0004;
            send(1'b0, d);
            chk({31'h0, switch_alert}, {31'h0, exp_alert(d, up, lo)});
            if (d[15:2] > up[15:2]) acc[0] = 1'b1;
            if (d[15:2] < lo[15:2]) acc[1] = 1'b1;
        end
        chk({31'h0, irq}, 32'h00000001);
        host.rd(10'h184, q);
        chk(q, {29'h0, acc});
        host.rd(10'h184, q);
        chk(q, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        $display("test compare done");
        host.wr(10'h180, 16'h0000);
        send(1'b0, 16'hFFFC);
        chk({31'h0, switch_alert}, 32'h00000000);
        chk({31'h0, test_en}, 32'h00000000);
        d = 16'h0000;
        for (int p = 1; p < 8; p++) begin
            host.wr(10'h180, 16'(p << 1));
            seed = xs(seed);
            d = seed[15:0];
            send(1'b1, d);
            chk({29'h0, selftest_pick}, 32'(p));
            host.rd(10'h140, q);
            chk(q, {16'h0000, d & 16'hFFFC});
            host.wr(10'h140, ~d);
            host.rd(10'h140, q);
            chk(q, {16'h0000, d & 16'hFFFC});
        end
        host.wr(10'h180, 16'h0000);
        send(1'b1, ~d);
        host.rd(10'h140, q);
        chk(q, {16'h0000, d & 16'hFFFC});
        chk({31'h0, irq}, 32'h00000001);
        host.rd(10'h184, q);
        chk(q, 32'h00000004);
        $display("test result done");
        host.wr(10'h188, 16'h0000);
        host.wr(10'h180, 16'h0001);
        send(1'b0, 16'hFFFC);
        chk({31'h0, switch_alert}, 32'h00000001);
        @(posedge core_clk);
        #1;
        chk({31'h0, irq}, 32'h00000000);
        ce <= 1'b0;
        send(1'b0, 16'hFFFC);
        chk({31'h0, switch_alert}, 32'h00000000);
        ce <= 1'b1;
        host.rd(10'h184, q);
        chk(q, 32'h00000001);
        host.rd(10'h135, q);
        chk(q, 32'h00000000);
        $display("test mask done");
        end_sim();
    end
endmodule
